/* rtl/spu_stack_unit.sv */
// stack pointer update unit with axi4-lite register access
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module spu_stack_unit (
	// clock, reset, enable
	input  wire logic                     core_clk_i,
	input  wire logic                     nrst_i,
	input  wire logic                     ce_i,
	// axi4-lite write address
	input  wire logic                     s_axi_awvalid_i,
	input  wire logic [7:0]               s_axi_awaddr_i,
	output logic                          s_axi_awready_o,
	// axi4-lite write data
	input  wire logic                     s_axi_wvalid_i,
	input  wire logic [31:0]              s_axi_wdata_i,
	input  wire logic [3:0]               s_axi_wstrb_i,
	output logic                          s_axi_wready_o,
	// axi4-lite write response
	output logic                          s_axi_bvalid_o,
	output logic [1:0]                    s_axi_bresp_o,
	input  wire logic                     s_axi_bready_i,
	// axi4-lite read
	input  wire logic                     s_axi_arvalid_i,
	input  wire logic [7:0]               s_axi_araddr_i,
	output logic                          s_axi_arready_o,
	output logic                          s_axi_rvalid_o,
	output logic [31:0]                   s_axi_rdata_o,
	output logic [1:0]                    s_axi_rresp_o,
	input  wire logic                     s_axi_rready_i,
	// stack memory port
	output spu_pkg::spu_mem_req_type      mem_req_o,
	input  wire logic                     mem_ack_i,
	input  wire logic [31:0]              mem_rdata_i,
	// current stack view
	output logic [15:0]                   stack_sel_o,
	output logic [31:0]                   stack_ptr_o,
	output logic                          busy_o
);

	// bus state
	logic                      awready_q;
	logic                      wready_q;
	logic                      aw_held_q;
	logic                      w_held_q;
	logic [7:0]                waddr_q;
	logic [31:0]               wdata_q;
	logic [3:0]                wstrb_q;
	logic                      bvalid_q;
	logic [1:0]                bresp_q;
	logic                      arready_q;
	logic                      rvalid_q;
	logic [31:0]               rdata_q;
	logic [1:0]                rresp_q;

	// block state
	logic [2:0]                ctrl_q;
	logic [15:0]               sel_q;
	logic [31:0]               ptr_q;
	logic [31:0]               stage_q;
	logic [31:0]               item_q;
	logic [31:0]               expl_q;
	logic                      done_q;
	logic                      op_sel_q;
	logic                      busy_q;
	spu_pkg::spu_state_type    state_q;
	spu_pkg::spu_mem_req_type  mem_q;

	// next values
	logic                      aw_held_d;
	logic                      w_held_d;
	logic                      bvalid_d;
	logic                      rvalid_d;
	logic [2:0]                ctrl_d;
	logic [15:0]               sel_d;
	logic [31:0]               ptr_d;
	logic [31:0]               stage_d;
	logic [31:0]               item_d;
	logic [31:0]               expl_d;
	logic                      done_d;
	logic                      op_sel_d;
	spu_pkg::spu_state_type    state_d;
	spu_pkg::spu_mem_req_type  mem_d;

	// handshakes
	wire logic aw_hs   = s_axi_awvalid_i & awready_q;
	wire logic w_hs    = s_axi_wvalid_i & wready_q;
	wire logic ar_hs   = s_axi_arvalid_i & arready_q;
	wire logic wr_fire = aw_held_q & w_held_q & ~bvalid_q;

	// width attributes
	wire logic code_d = ctrl_q[spu_pkg::CTRL_CODE_D];
	wire logic step32 = code_d;
	wire logic tos32  = ctrl_q[spu_pkg::CTRL_STACK_B];
	wire logic expl32 = code_d ^ ctrl_q[spu_pkg::CTRL_ADDR_OVR];
	wire logic busy   = (state_q != spu_pkg::ST_IDLE);

	// write decode
	wire logic [7:0] wa  = {waddr_q[7:2], 2'b00};
	wire logic hit_ctrl  = (wa == spu_pkg::OFF_CTRL);
	wire logic hit_sel   = (wa == spu_pkg::OFF_SEL);
	wire logic hit_ptr   = (wa == spu_pkg::OFF_PTR);
	wire logic hit_comb  = (wa == spu_pkg::OFF_COMB);
	wire logic hit_stage = (wa == spu_pkg::OFF_STAGE);
	wire logic hit_item  = (wa == spu_pkg::OFF_ITEM);
	wire logic hit_cmd   = (wa == spu_pkg::OFF_CMD);
	wire logic hit_expl  = (wa == spu_pkg::OFF_EXPL);
	wire logic hit_stat  = (wa == spu_pkg::OFF_STATUS);
	wire logic w_mapped  = hit_ctrl | hit_sel | hit_ptr | hit_comb | hit_stage
		| hit_item | hit_cmd | hit_expl | hit_stat;
	// stack identity and widths stay frozen while an operation is running
	wire logic w_locked  = busy & (hit_ctrl | hit_sel | hit_ptr | hit_comb | hit_item | hit_cmd);
	wire logic wr_bad    = ~w_mapped | w_locked;
	wire logic wr_ok     = wr_fire & ~wr_bad;

	// merged write values
	wire logic [31:0] ctrl_wv = spu_pkg::apply_strb({29'h0, ctrl_q}, wdata_q, wstrb_q);
	wire logic [31:0] sel_wv  = spu_pkg::apply_strb({16'h0000, sel_q}, wdata_q, wstrb_q);
	wire logic [31:0] ptr_wv  = spu_pkg::apply_strb(ptr_q, wdata_q, wstrb_q);
	wire logic [31:0] stg_wv  = spu_pkg::apply_strb(stage_q, wdata_q, wstrb_q);
	wire logic [31:0] item_wv = spu_pkg::apply_strb(item_q, wdata_q, wstrb_q);
	wire logic [31:0] expl_wv = spu_pkg::apply_strb(expl_q, wdata_q, wstrb_q);

	// commands, low byte lane only
	wire logic cmd_lane  = wr_ok & hit_cmd & wstrb_q[0];
	wire logic start_psh = cmd_lane & (wdata_q[spu_pkg::CMD_PUSH] | wdata_q[spu_pkg::CMD_PUSH_SEL]);
	wire logic start_pop = cmd_lane & wdata_q[spu_pkg::CMD_POP] & ~start_psh;
	wire logic done_clr  = wr_ok & hit_stat & wstrb_q[0] & wdata_q[spu_pkg::STAT_DONE];

	// address arithmetic
	logic [31:0] tos_addr;
	logic [31:0] push_ptr;
	logic [31:0] pop_ptr;

	spu_addr_calc u_calc (
		.ptr_i      (ptr_q),
		.step32_i   (step32),
		.tos32_i    (tos32),
		.tos_addr_o (tos_addr),
		.push_ptr_o (push_ptr),
		.pop_ptr_o  (pop_ptr)
	);

	// memory sequencing
	wire logic in_push_adj = (state_q == spu_pkg::ST_PUSH_ADJ);
	wire logic in_push_wr  = (state_q == spu_pkg::ST_PUSH_WR);
	wire logic in_pop_rd   = (state_q == spu_pkg::ST_POP_RD);
	wire logic in_pop_adj  = (state_q == spu_pkg::ST_POP_ADJ);
	wire logic issue       = (in_push_wr | in_pop_rd) & ~mem_q.req;
	wire logic acked       = mem_q.req & mem_ack_i;

	// a selector is 16 bits but still takes a full stack-width slot
	wire logic [31:0] push_item = op_sel_q ? {16'h0000, sel_q}
		: (step32 ? item_q : spu_pkg::low16(item_q));
	wire logic [31:0] pop_item  = step32 ? mem_rdata_i : spu_pkg::low16(mem_rdata_i);

	assign state_d =
		(state_q == spu_pkg::ST_IDLE & start_psh) ? spu_pkg::ST_PUSH_ADJ :
		(state_q == spu_pkg::ST_IDLE & start_pop) ? spu_pkg::ST_POP_RD :
		in_push_adj                               ? spu_pkg::ST_PUSH_WR :
		(in_push_wr & acked)                      ? spu_pkg::ST_IDLE :
		(in_pop_rd & acked)                       ? spu_pkg::ST_POP_ADJ :
		in_pop_adj                                ? spu_pkg::ST_IDLE :
		state_q;

	// pointer moves before the write and after the read
	assign ptr_d =
		in_push_adj          ? push_ptr :
		in_pop_adj           ? pop_ptr :
		(wr_ok & hit_comb)   ? stage_q :
		(wr_ok & hit_ptr)    ? ptr_wv :
		ptr_q;

	assign sel_d =
		(wr_ok & (hit_sel | hit_comb)) ? sel_wv[15:0] : sel_q;

	assign ctrl_d   = (wr_ok & hit_ctrl) ? ctrl_wv[2:0] : ctrl_q;
	assign stage_d  = (wr_ok & hit_stage) ? stg_wv : stage_q;
	assign expl_d   = (wr_ok & hit_expl) ? expl_wv : expl_q;
	assign item_d   = (in_pop_rd & acked) ? pop_item : (wr_ok & hit_item) ? item_wv : item_q;
	assign op_sel_d = start_psh ? wdata_q[spu_pkg::CMD_PUSH_SEL] : op_sel_q;

	// completion flag: a finishing operation beats a clear in the same cycle
	wire logic done_set = (in_push_wr & acked) | in_pop_adj;
	assign done_d = done_set | (done_q & ~done_clr);

	// request: segment always the current selector, address from the current pointer, already lowered for a push and not yet raised for a pop
	assign mem_d.req   = issue | (mem_q.req & ~mem_ack_i);
	assign mem_d.we    = issue ? in_push_wr : mem_q.we;
	assign mem_d.wide  = issue ? step32 : mem_q.wide;
	assign mem_d.seg   = issue ? sel_q : mem_q.seg;
	assign mem_d.addr  = issue ? tos_addr : mem_q.addr;
	assign mem_d.wdata = (issue & in_push_wr) ? push_item : mem_q.wdata;

	// bus next values
	assign aw_held_d = wr_fire ? 1'b0 : (aw_held_q | aw_hs);
	assign w_held_d  = wr_fire ? 1'b0 : (w_held_q | w_hs);
	assign bvalid_d  = wr_fire | (bvalid_q & ~s_axi_bready_i);
	assign rvalid_d  = ar_hs | (rvalid_q & ~s_axi_rready_i);

	// read decode
	wire logic [7:0] ra = {s_axi_araddr_i[7:2], 2'b00};
	wire logic [31:0] status_word = {27'h0, expl32, step32, tos32, done_q, busy};
	wire logic [31:0] expl_view   = expl32 ? expl_q : spu_pkg::low16(expl_q);
	wire logic r_mapped =
		(ra == spu_pkg::OFF_CTRL) | (ra == spu_pkg::OFF_SEL) | (ra == spu_pkg::OFF_PTR)
		| (ra == spu_pkg::OFF_COMB) | (ra == spu_pkg::OFF_STAGE) | (ra == spu_pkg::OFF_ITEM)
		| (ra == spu_pkg::OFF_CMD) | (ra == spu_pkg::OFF_EXPL) | (ra == spu_pkg::OFF_STATUS);
	wire logic [31:0] rd_word =
		(ra == spu_pkg::OFF_CTRL)   ? {29'h0, ctrl_q} :
		(ra == spu_pkg::OFF_SEL)    ? {16'h0000, sel_q} :
		(ra == spu_pkg::OFF_PTR)    ? ptr_q :
		(ra == spu_pkg::OFF_STAGE)  ? stage_q :
		(ra == spu_pkg::OFF_ITEM)   ? item_q :
		(ra == spu_pkg::OFF_EXPL)   ? expl_view :
		(ra == spu_pkg::OFF_STATUS) ? status_word :
		32'h0000_0000;

	// write channel
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			waddr_q   <= 8'h00;
			wdata_q   <= spu_pkg::WORD_RST;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= spu_pkg::RESP_OKAY;
		end else if (ce_i) begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awready_q <= ~aw_held_d & ~bvalid_d;
			wready_q  <= ~w_held_d & ~bvalid_d;
			if (aw_hs) begin
				waddr_q <= s_axi_awaddr_i;
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			bvalid_q <= bvalid_d;
			if (wr_fire) begin
				bresp_q <= wr_bad ? spu_pkg::RESP_SLVERR : spu_pkg::RESP_OKAY;
			end
		end
	end

	// read channel
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= spu_pkg::WORD_RST;
			rresp_q   <= spu_pkg::RESP_OKAY;
		end else if (ce_i) begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_hs) begin
				rdata_q <= rd_word;
				rresp_q <= r_mapped ? spu_pkg::RESP_OKAY : spu_pkg::RESP_SLVERR;
			end
		end
	end

	// stack registers and sequencer
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q  <= spu_pkg::ST_IDLE;
			ctrl_q   <= spu_pkg::CTRL_RST;
			sel_q    <= spu_pkg::SEL_RST;
			ptr_q    <= spu_pkg::WORD_RST;
			stage_q  <= spu_pkg::WORD_RST;
			item_q   <= spu_pkg::WORD_RST;
			expl_q   <= spu_pkg::WORD_RST;
			done_q   <= 1'b0;
			op_sel_q <= 1'b0;
			busy_q   <= 1'b0;
			mem_q    <= spu_pkg::MEM_RST;
		end else if (ce_i) begin
			state_q  <= state_d;
			ctrl_q   <= ctrl_d;
			sel_q    <= sel_d;
			ptr_q    <= ptr_d;
			stage_q  <= stage_d;
			item_q   <= item_d;
			expl_q   <= expl_d;
			done_q   <= done_d;
			op_sel_q <= op_sel_d;
			busy_q   <= (state_d != spu_pkg::ST_IDLE);
			mem_q    <= mem_d;
		end
	end

	// outputs
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o  = wready_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;
	assign mem_req_o       = mem_q;
	assign stack_sel_o     = sel_q;
	assign stack_ptr_o     = ptr_q;
	assign busy_o          = busy_q;

endmodule // spu_stack_unit
`default_nettype wire

/* rtl/spu_pkg.sv */
// constants, types and helpers shared by the stack pointer update block
// Operation
// - push lowers the pointer by the item size, then writes at the new top
// - pop reads the item at the current top, then raises the pointer
// - every stack access uses the current stack segment selector, never an override
// - one current stack only; loading a new selector switches it
// - push and pop step size comes from the code segment width flag
// - 16-bit width steps by two bytes, 32-bit width by four bytes
// - selector push onto a 32-bit stack moves a full 32-bit step
// - pointer alignment is never checked and never faults
// - stack operations carry separate top-of-stack and explicit operand address sizes
// - explicit operand size is code width flag toggled by the override prefix
// - 16-bit top-of-stack size uses only the low pointer half
// - 32-bit top-of-stack size uses the full 32-bit pointer
// - top-of-stack size is 16 with stack width flag clear, 32 when set
// - a stack segment may span the full 32-bit address range
// - one combined load writes selector and pointer in a single operation
package spu_pkg;

	// register byte offsets
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_SEL        = 8'h04;
	localparam logic [7:0]  OFF_PTR        = 8'h08;
	localparam logic [7:0]  OFF_COMB       = 8'h0c;
	localparam logic [7:0]  OFF_STAGE      = 8'h10;
	localparam logic [7:0]  OFF_ITEM       = 8'h14;
	localparam logic [7:0]  OFF_CMD        = 8'h18;
	localparam logic [7:0]  OFF_EXPL       = 8'h1c;
	localparam logic [7:0]  OFF_STATUS     = 8'h20;

	// control field positions
	localparam int          CTRL_CODE_D    = 0;
	localparam int          CTRL_STACK_B   = 1;
	localparam int          CTRL_ADDR_OVR  = 2;

	// command field positions
	localparam int          CMD_PUSH       = 0;
	localparam int          CMD_POP        = 1;
	localparam int          CMD_PUSH_SEL   = 2;

	// status field positions
	localparam int          STAT_BUSY      = 0;
	localparam int          STAT_DONE      = 1;
	localparam int          STAT_TOS32     = 2;
	localparam int          STAT_STEP32    = 3;
	localparam int          STAT_EXPL32    = 4;

	// reset values
	localparam logic [2:0]  CTRL_RST       = 3'h0;
	localparam logic [15:0] SEL_RST        = 16'h0000;
	localparam logic [31:0] WORD_RST       = 32'h0000_0000;

	// pointer steps in bytes
	localparam logic [31:0] STEP16         = 32'h0000_0002;
	localparam logic [31:0] STEP32         = 32'h0000_0004;

	// bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_PUSH_ADJ = 3'h1,
		ST_PUSH_WR  = 3'h3,
		ST_POP_RD   = 3'h4,
		ST_POP_ADJ  = 3'h5
	} spu_state_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        wide;
		logic [15:0] seg;
		logic [31:0] addr;
		logic [31:0] wdata;
	} spu_mem_req_type;

	localparam spu_mem_req_type MEM_RST = '{req: 1'b0, we: 1'b0, wide: 1'b0,
		seg: 16'h0000, addr: 32'h0000_0000, wdata: 32'h0000_0000};

	function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] low16(input logic [31:0] v);
		return {16'h0000, v[15:0]};
	endfunction

endpackage

/* rtl/spu_addr_calc.sv */
// pointer step and top-of-stack address arithmetic
`timescale 1ns/100ps
`default_nettype none
module spu_addr_calc (
	// current pointer and widths
	input  wire logic [31:0] ptr_i,
	input  wire logic        step32_i,
	input  wire logic        tos32_i,
	// results
	output logic      [31:0] tos_addr_o,
	output logic      [31:0] push_ptr_o,
	output logic      [31:0] pop_ptr_o
);

	wire logic [31:0] step;
	wire logic [31:0] dec;
	wire logic [31:0] inc;

	assign step = step32_i ? spu_pkg::STEP32 : spu_pkg::STEP16;
	assign dec  = ptr_i - step;
	assign inc  = ptr_i + step;

	// low half only in 16-bit mode, upper half is left for software
	assign push_ptr_o = tos32_i ? dec : {ptr_i[31:16], dec[15:0]};
	assign pop_ptr_o  = tos32_i ? inc : {ptr_i[31:16], inc[15:0]};

	// no alignment mask: odd pointers go straight to memory
	assign tos_addr_o = tos32_i ? ptr_i : spu_pkg::low16(ptr_i);

endmodule // spu_addr_calc
`default_nettype wire

/* sim/spu_mem_model.sv */
// behavioural stack memory answering the unit's memory port
`timescale 1ns/100ps
`default_nettype none
module spu_mem_model (
	// clock and reset
	input  wire logic                    core_clk_i,
	input  wire logic                    nrst_i,
	// request side
	input  wire spu_pkg::spu_mem_req_type req_i,
	input  wire logic [2:0]              lat_i,
	output logic                         ack_o,
	output logic [31:0]                  rdata_o
);
	logic [7:0] mem [logic [31:0]];
	logic [2:0] wait_q;

	function automatic logic [7:0] rd8(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 8'ha5;
	endfunction

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_o <= 1'b0;
			wait_q <= 3'h0;
			rdata_o <= 32'h0000_0000;
		end else begin
			ack_o <= 1'b0;
			// released data lines toggle so a stale sample shows up
			rdata_o <= ~rdata_o;
			if (req_i.req && !ack_o) begin
				if (wait_q == lat_i) begin
					ack_o <= 1'b1;
					wait_q <= 3'h0;
					// any 32-bit address is backed, no segment limit here
					for (int i = 0; i < 4; i++) begin
						if (req_i.we && (i < 2 || req_i.wide)) begin
							mem[32'(req_i.addr + i)] = req_i.wdata[i*8 +: 8];
						end
					end
					rdata_o <= {rd8(req_i.addr + 32'h3), rd8(req_i.addr + 32'h2),
						rd8(req_i.addr + 32'h1), rd8(req_i.addr)};
				end else begin
					wait_q <= wait_q + 3'h1;
				end
			end
		end
	end
endmodule // spu_mem_model
`default_nettype wire

/* sim/spu_stack_unit_properties.sv */
// concurrent checks on the stack unit's memory port and pointer
`timescale 1ns/100ps
`default_nettype none
module spu_stack_unit_properties (
	// clock and reset
	input  wire logic                    core_clk_i,
	input  wire logic                    nrst_i,
	// memory port and stack view
	input  wire spu_pkg::spu_mem_req_type mem_req_o,
	input  wire logic                    mem_ack_i,
	input  wire logic [15:0]             stack_sel_o,
	input  wire logic [31:0]             stack_ptr_o,
	input  wire logic                    busy_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_push_start;
		$rose(mem_req_o.req) && mem_req_o.we;
	endsequence
	sequence s_pop_ack;
		mem_req_o.req && !mem_req_o.we && mem_ack_i;
	endsequence

	property p_push_dec;
		s_push_start |-> stack_ptr_o[15:0] ==
			$past(stack_ptr_o[15:0], 2) - (mem_req_o.wide ? 16'h0004 : 16'h0002);
	endproperty
	property p_upper_kept;
		s_push_start and (mem_req_o.addr != stack_ptr_o) |->
			stack_ptr_o[31:16] == $past(stack_ptr_o[31:16], 2);
	endproperty
	property p_addr_top;
		mem_req_o.req |-> mem_req_o.addr == stack_ptr_o ||
			mem_req_o.addr == {16'h0000, stack_ptr_o[15:0]};
	endproperty
	property p_seg;
		mem_req_o.req |-> mem_req_o.seg == stack_sel_o;
	endproperty
	property p_hold;
		mem_req_o.req && !mem_ack_i |=> mem_req_o.req && $stable(mem_req_o);
	endproperty
	property p_drop;
		mem_req_o.req && mem_ack_i |=> !mem_req_o.req;
	endproperty
	property p_busy;
		mem_req_o.req |-> busy_o;
	endproperty
	property p_pop_read_first;
		s_pop_ack |=> $stable(stack_ptr_o);
	endproperty
	property p_pop_inc;
		s_pop_ack |-> ##2 stack_ptr_o[15:0] == $past(stack_ptr_o[15:0], 2) +
			($past(mem_req_o.wide, 2) ? 16'h0004 : 16'h0002);
	endproperty

	a_push_dec: assert property (p_push_dec) else $error("push step wrong");
	a_upper_kept: assert property (p_upper_kept) else $error("upper half moved");
	a_addr_top: assert property (p_addr_top) else $error("stack address wrong");
	a_seg: assert property (p_seg) else $error("segment not current");
	a_hold: assert property (p_hold) else $error("request not held");
	a_drop: assert property (p_drop) else $error("request not dropped");
	a_busy: assert property (p_busy) else $error("request while idle");
	a_pop_read_first: assert property (p_pop_read_first) else $error("pop moved early");
	a_pop_inc: assert property (p_pop_inc) else $error("pop step wrong");
endmodule // spu_stack_unit_properties

bind spu_stack_unit spu_stack_unit_properties spu_stack_unit_properties_inst (
	.core_clk_i, .nrst_i, .mem_req_o, .mem_ack_i, .stack_sel_o, .stack_ptr_o, .busy_o);
`default_nettype wire

/* sim/stack_pointer_update_bench.sv */
// self-checking bench for the stack pointer update unit
`timescale 1ns/100ps
`default_nettype none
module stack_pointer_update_bench;
	logic core_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, mem_rdata_i;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o, stack_ptr_o;
	logic [15:0] stack_sel_o;
	logic mem_ack_i, busy_o;
	logic [2:0] lat = 3'h0;
	spu_pkg::spu_mem_req_type mem_req_o, lreq;
	int fails = 0, check_count = 0;
	logic [31:0] st = 32'h0000_000e;

	always #50 core_clk_i = ~core_clk_i;

	spu_stack_unit spu_stack_unit_inst (.*);
	spu_mem_model spu_mem_model_inst (.core_clk_i, .nrst_i, .req_i(mem_req_o), .lat_i(lat),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	always @(posedge core_clk_i) if (mem_req_o.req && mem_ack_i) lreq <= mem_req_o;

	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	function automatic logic [31:0] mv(input logic [31:0] p, input logic t, input logic [31:0] d);
		return t ? p + d : {p[31:16], p[15:0] + d[15:0]};
	endfunction
	function automatic logic [31:0] top(input logic [31:0] p, input logic t);
		return t ? p : {16'h0000, p[15:0]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1 && n < 50);
		s_axi_bready_i <= 1'b0;
		chk("bvalid", 32'h1, {31'h0, s_axi_bvalid_o});
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
		@(posedge core_clk_i);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		int n;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1 && n < 50);
		s_axi_rready_i <= 1'b0;
		chk("rvalid", 32'h1, {31'h0, s_axi_rvalid_o});
		chk("rdata", e, s_axi_rdata_o);
		chk("rresp", {30'h0, a > 8'h20 ? 2'h2 : 2'h0}, {30'h0, s_axi_rresp_o});
		@(posedge core_clk_i);
	endtask
	task automatic op(input logic [31:0] cmd, input logic refuse);
		int n;
		wr(spu_pkg::OFF_CMD, cmd, 2'h0);
		if (refuse) wr(spu_pkg::OFF_PTR, 32'h0, 2'h2);
		n = 0;
		while (busy_o !== 1'b0 && n < 200) begin
			@(posedge core_clk_i);
			n++;
		end
		chk("busy", 32'h0, {31'h0, busy_o});
		@(posedge core_clk_i);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		logic [31:0] p, np, item, m, r;
		logic [15:0] s;
		logic cd, t;
		repeat (5) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		for (int a = 0; a <= 36; a += 4) rc(a[7:0], 32'h0);
		wr(8'h24, xs(), 2'h2);
		$display("test reset done");
		for (int j = 0; j < 8; j++) begin
			wr(spu_pkg::OFF_CTRL, 32'(j), 2'h0);
			wr(spu_pkg::OFF_EXPL, 32'h1234_5678, 2'h0);
			rc(spu_pkg::OFF_EXPL, (j[0] ^ j[2]) ? 32'h1234_5678 : 32'h0000_5678);
			rc(spu_pkg::OFF_STATUS, {27'h0, j[0] ^ j[2], j[0], j[1], 2'h0});
		end
		// upper lanes only, the low half must survive the merge
		s_axi_wstrb_i <= 4'hc;
		wr(spu_pkg::OFF_EXPL, 32'hffff_0000, 2'h0);
		s_axi_wstrb_i <= 4'hf;
		wr(spu_pkg::OFF_CTRL, 32'h1, 2'h0);
		rc(spu_pkg::OFF_EXPL, 32'hffff_5678);
		$display("test operand size done");
		for (int i = 0; i < 6; i++) begin
			cd = (i == 5) | i[0];
			t = (i == 5) | i[1];
			m = cd ? 32'hffff_ffff : 32'h0000_ffff;
			r = xs();
			// aligned pointers as software keeps them, then two odd corners
			p = (i == 4) ? 32'habcd_0001 : (i == 5) ? 32'h0000_0002 : r & ~{30'h0, cd, 1'b1};
			r = xs();
			s = r[15:0];
			wr(spu_pkg::OFF_STAGE, p, 2'h0);
			wr(spu_pkg::OFF_COMB, {16'h0, s}, 2'h0);
			chk("sel", {16'h0, s}, {16'h0, stack_sel_o});
			rc(spu_pkg::OFF_PTR, p);
			wr(spu_pkg::OFF_CTRL, {30'h0, t, cd}, 2'h0);
			item = xs();
			wr(spu_pkg::OFF_ITEM, item, 2'h0);
			r = xs();
			lat <= (i == 2) ? 3'h7 : r[2:0];
			op(32'h1, i == 2);
			np = mv(p, t, 32'h0 - (cd ? 32'h4 : 32'h2));
			chk("push ptr", np, stack_ptr_o);
			chk("push addr", top(np, t), lreq.addr);
			chk("seg", {16'h0, s}, {16'h0, lreq.seg});
			chk("we wide", {30'h0, cd, 1'b1}, {30'h0, lreq.wide, lreq.we});
			chk("wdata", item & m, lreq.wdata & m);
			wr(spu_pkg::OFF_ITEM, 32'h0, 2'h0);
			op(32'h2, 1'b0);
			chk("pop ptr", p, stack_ptr_o);
			chk("pop addr", top(np, t), lreq.addr);
			rc(spu_pkg::OFF_ITEM, item & m);
			rc(spu_pkg::OFF_STATUS, {27'h0, cd, cd, t, 2'h2});
			wr(spu_pkg::OFF_STATUS, 32'h2, 2'h0);
			rc(spu_pkg::OFF_STATUS, {27'h0, cd, cd, t, 2'h0});
			if (i == 3) begin
				op(32'h4, 1'b0);
				chk("sel push ptr", p - 32'h4, stack_ptr_o);
				chk("sel push data", {16'h0, s}, lreq.wdata);
				chk("sel push wide", 32'h1, {31'h0, lreq.wide});
			end
			$display("test mode %0d done", i);
		end
		close_out;
	end

	// roughly five times the expected run length
	initial begin
		#300000;
		fails++;
		close_out;
	end
endmodule // stack_pointer_update_bench
`default_nettype wire
